// ==== logic/dcapi_params.svh ====
/*
  Constants for the channel A DRAM pin interface: reset values, mode words and timing counts.
  Assumes the system clock runs at 125 MHz and that it is included by the design files only.
*/
`ifndef DCAPI_PARAMS_SVH
`define DCAPI_PARAMS_SVH

`define DCAPI_CLK_NS 8
`define DCAPI_HALF 2
`define DCAPI_FIFO_DEPTH 32
`define DCAPI_INIT_STEPS 7
`define DCAPI_INIT_WAIT_NS 200000
`define DCAPI_INIT_WAIT_CYC ((`DCAPI_INIT_WAIT_NS + `DCAPI_CLK_NS - 1) / `DCAPI_CLK_NS)
`define DCAPI_GAP_NS 75
`define DCAPI_GAP_CYC ((`DCAPI_GAP_NS + `DCAPI_CLK_NS - 1) / `DCAPI_CLK_NS)
`define DCAPI_XSR_NS 1600
`define DCAPI_XSR_CYC ((`DCAPI_XSR_NS + `DCAPI_CLK_NS - 1) / `DCAPI_CLK_NS)
`define DCAPI_CS_IDLE 4'hf
`define DCAPI_ADDR_ALL 13'h0400
`define DCAPI_A10 10
`define DCAPI_MODE_RUN 13'h0021
`define DCAPI_MODE_DLLRST 13'h0121
`define DCAPI_EMODE 13'h0000

`endif

// ==== logic/dcapi_pkg.sv ====
/*
  Types shared by the channel A DRAM pin interface: command codes and controller states.
  Assumes nothing of its surroundings.
*/
package dcapi_pkg;

  // Codes are the {row, column, write} strobe levels, all active low.
  typedef enum logic [2:0] {
    DCAPI_MRS = 3'h0,
    DCAPI_REF = 3'h1,
    DCAPI_PRE = 3'h2,
    DCAPI_ACT = 3'h3,
    DCAPI_WR  = 3'h4,
    DCAPI_RD  = 3'h5,
    DCAPI_BST = 3'h6,
    DCAPI_NOP = 3'h7
  } dcapi_cmd_t;

  typedef enum logic [2:0] {
    ST_INIT_WAIT = 3'h0,
    ST_INIT_SEQ  = 3'h1,
    ST_IDLE      = 3'h3,
    ST_WRITE     = 3'h2,
    ST_SREF      = 3'h7,
    ST_SREF_EXIT = 3'h5
  } dcapi_state_t;

endpackage : dcapi_pkg

// ==== logic/dcapi_rd_if.sv ====
/*
  Carrier between the channel core and its read capture: raw data and strobe pins in, beats out.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
interface dcapi_rd_if;
  logic [63:0] dq_pin;
  logic [7:0]  dqs_pin;
  logic        listen;
  logic        beat_valid;
  logic [63:0] beat_data;
  modport core (output dq_pin, output dqs_pin, output listen, input beat_valid, input beat_data);
  modport capt (input dq_pin, input dqs_pin, input listen, output beat_valid, output beat_data);
endinterface : dcapi_rd_if

// ==== logic/dcapi_fifo.sv ====
/*
  Write data FIFO with its own storage and a registered read word.
  Assumes one clock; DEPTH is a power of two.
*/
`timescale 1ns/10ps
module dcapi_fifo
  import dcapi_pkg::*;
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH)+1:0]        level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dcapi_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;

  wire push = in_valid & in_ready;
  wire load = (cnt != '0) & (~out_valid | out_ready);

  // The output register holds a word too, so it counts towards the depth.
  assign in_ready = level != (AW+2)'(DEPTH);
  assign level    = {1'b0, cnt} + (AW+2)'(out_valid);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wp  <= wp + AW'(push);
      rp  <= rp + AW'(load);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(load);
      if (load) begin
        out_data  <= mem[rp];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_fifo_count: assert property (push && !load |=> cnt == $past(cnt) + 1'b1)
    else $error("fifo count did not follow a push");
endmodule : dcapi_fifo

// ==== logic/dcapi_capture.sv ====
/*
  Read capture: synchronises the returned data and strobes and takes each lane on its strobe.
  Assumes the strobes toggle far slower than clk_sys, as the link clock does.
*/
`timescale 1ns/10ps
module dcapi_capture
  import dcapi_pkg::*;
#(
  parameter int LANES = 8
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  dcapi_rd_if.capt  rd
);
  if (LANES != 8) begin : g_bad_lanes
    $error("dcapi_capture: the data bus carries exactly eight byte lanes");
  end

  logic [LANES*8-1:0] dq_s1;
  logic [LANES*8-1:0] dq_s2;
  logic [LANES-1:0]   dqs_s1;
  logic [LANES-1:0]   dqs_s2;
  logic [LANES-1:0]   dqs_s3;
  logic [LANES-1:0]   edge_d;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dq_s1  <= '0;
      dq_s2  <= '0;
      dqs_s1 <= '0;
      dqs_s2 <= '0;
      dqs_s3 <= '0;
    end else begin
      dq_s1  <= rd.dq_pin;
      dq_s2  <= dq_s1;
      dqs_s1 <= rd.dqs_pin;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
    end
  end

  // Data is edge aligned, so each lane waits one cycle past its strobe edge to sit mid-eye.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        edge_d[g]           <= 1'b0;
        rd.beat_data[8*g+:8] <= 8'h00;
      end else begin
        edge_d[g] <= rd.listen & (dqs_s2[g] ^ dqs_s3[g]);
        if (edge_d[g]) begin
          rd.beat_data[8*g+:8] <= dq_s2[8*g+:8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd.beat_valid <= 1'b0;
    end else begin
      rd.beat_valid <= edge_d[0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_beat_listen: assert property (rd.beat_valid |-> $past(rd.listen, 2))
    else $error("read beat taken while the bus was driven");
endmodule : dcapi_capture

// ==== logic/dcapi_channel.sv ====
/*
  Channel A DRAM pin interface: clock forwarding, init, commands, power states and data.
  Assumes a user that issues raw commands and keeps DRAM timing between them.
*/
`timescale 1ns/10ps
`include "dcapi_params.svh"
module dcapi_channel
  import dcapi_pkg::*;
#(
  parameter int HALF          = `DCAPI_HALF,
  parameter int INIT_WAIT_CYC = `DCAPI_INIT_WAIT_CYC,
  parameter int FIFO_DEPTH    = `DCAPI_FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [2:0]  cmd_code,
  input  wire logic [1:0]  cmd_rank,
  input  wire logic [1:0]  cmd_bank,
  input  wire logic [12:0] cmd_addr,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [63:0] wr_data,
  output logic             rd_valid,
  output logic [63:0]      rd_data,
  input  wire logic        suspend_req,
  input  wire logic [3:0]  pd_req,
  output logic             init_done,
  output logic             in_self_refresh,
  output logic [5:0]       mem_clk_out_true,
  output logic [5:0]       mem_clk_out_comp,
  output logic [3:0]       row_select_n,
  output logic [3:0]       row_clk_en,
  output logic [12:0]      mux_row_col_addr,
  output logic [5:1]       addr_low_copy,
  output logic [1:0]       bank_sel,
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic             write_en_n,
  input  wire logic [63:0] mem_data_bus_in,
  output logic [63:0]      mem_data_bus_out,
  output logic             mem_data_bus_oe,
  input  wire logic [7:0]  byte_lane_strobe_in,
  output logic [7:0]       byte_lane_strobe_out,
  output logic             byte_lane_strobe_oe
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [15:0] GAP = 16'(`DCAPI_GAP_CYC);
  localparam logic [15:0] XSR = 16'(`DCAPI_XSR_CYC);

  // The write strobe sits at the middle of each half period, so that must be a whole cycle.
  if (HALF < 2 || HALF % 2 != 0) begin : g_bad_half
    $error("dcapi_channel: HALF must be even and at least 2");
  end
  if (INIT_WAIT_CYC < 1 || INIT_WAIT_CYC > 65535) begin : g_bad_wait
    $error("dcapi_channel: INIT_WAIT_CYC must fit 16 bits");
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Memory clock divider.

  logic [CW-1:0] ph;
  logic          clk_q;
  logic          clk_nq;

  wire tick    = ph == CW'(HALF - 1);
  wire rise_en = tick & ~clk_q;
  wire fall_en = tick & clk_q;
  wire mid_en  = ph == CW'(HALF / 2 - 1);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ph     <= '0;
      clk_q  <= 1'b0;
      clk_nq <= 1'b1;
    end else begin
      ph <= tick ? '0 : ph + 1'b1;
      if (tick) begin
        clk_q  <= ~clk_q;
        clk_nq <= clk_q;
      end
    end
  end

  assign mem_clk_out_true = {6{clk_q}};
  assign mem_clk_out_comp = {6{clk_nq}};

  //////////////////////////////////////////////////////////////////////////////////////////
  // Command selection.

  dcapi_state_t state;
  logic [15:0]  wt;
  logic [2:0]   step;
  logic [1:0]   wb;
  logic [15:0]  open_bk;
  logic [3:0]   open_row;
  logic [3:0]   iss_cs;
  logic [2:0]   iss_cmd;
  logic [1:0]   iss_bank;
  logic [12:0]  iss_addr;
  logic [3:0]   next_cke;
  logic [6:0]   fifo_level;
  logic         fifo_valid;
  logic [63:0]  fifo_data;

  wire [3:0] rank_hot = 4'h1 << cmd_rank;
  wire       wr_cmd   = cmd_code == DCAPI_WR;
  wire       wr_room  = fifo_level >= 7'h02;
  wire       take     = cmd_valid & cmd_ready;
  wire       sref_go  = rise_en & suspend_req & (open_row == 4'h0);
  wire       fifo_pop = (state == ST_WRITE) & ((rise_en & wb == 2'h0) | (fall_en & wb == 2'h1));

  assign cmd_ready = (state == ST_IDLE) & rise_en & ~suspend_req & row_clk_en[cmd_rank]
                   & (~wr_cmd | wr_room);

  function automatic logic [17:0] init_step(input logic [2:0] s);
    case (s)
      3'h0: init_step = {DCAPI_PRE, 2'h0, `DCAPI_ADDR_ALL};
      3'h1: init_step = {DCAPI_MRS, 2'h1, `DCAPI_EMODE};
      3'h2: init_step = {DCAPI_MRS, 2'h0, `DCAPI_MODE_DLLRST};
      3'h3: init_step = {DCAPI_PRE, 2'h0, `DCAPI_ADDR_ALL};
      3'h4: init_step = {DCAPI_REF, 2'h0, 13'h0000};
      3'h5: init_step = {DCAPI_REF, 2'h0, 13'h0000};
      default: init_step = {DCAPI_MRS, 2'h0, `DCAPI_MODE_RUN};
    endcase
  endfunction : init_step

  always_comb begin
    iss_cs   = `DCAPI_CS_IDLE;
    iss_cmd  = DCAPI_NOP;
    iss_bank = bank_sel;
    iss_addr = mux_row_col_addr;
    next_cke = row_clk_en;
    case (state)
      ST_INIT_WAIT: begin
        if (wt == 16'h0000) begin
          next_cke = 4'hf;
        end
      end
      ST_INIT_SEQ: begin
        if (wt == 16'h0000) begin
          iss_cs = 4'h0;
          {iss_cmd, iss_bank, iss_addr} = init_step(step);
        end
      end
      ST_IDLE: begin
        if (suspend_req) begin
          iss_cs = 4'h0;
          if (open_row != 4'h0) begin
            iss_cmd  = DCAPI_PRE;
            iss_addr = `DCAPI_ADDR_ALL;
          end else begin
            iss_cmd  = DCAPI_REF;
            next_cke = 4'h0;
          end
        end else begin
          if (take) begin
            iss_cs   = ~rank_hot;
            iss_cmd  = cmd_code;
            iss_bank = cmd_bank;
            iss_addr = cmd_addr;
          end
          next_cke = ~(pd_req & ~open_row) | (take ? rank_hot : 4'h0);
        end
      end
      ST_SREF: begin
        if (!suspend_req) begin
          next_cke = 4'hf;
        end
      end
      default: begin
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Pin registers, loaded only as the memory clock rises.

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      row_select_n                          <= `DCAPI_CS_IDLE;
      {row_strobe_n, col_strobe_n, write_en_n} <= DCAPI_NOP;
      bank_sel                              <= 2'h0;
      mux_row_col_addr                      <= 13'h0000;
      addr_low_copy                         <= 5'h00;
      row_clk_en                            <= 4'h0;
    end else if (rise_en) begin
      row_select_n                          <= iss_cs;
      {row_strobe_n, col_strobe_n, write_en_n} <= iss_cmd;
      bank_sel                              <= iss_bank;
      mux_row_col_addr                      <= iss_addr;
      addr_low_copy                         <= iss_addr[5:1];
      row_clk_en                            <= next_cke;
    end
  end

  // Open banks are tracked per row so that a row holding an open bank is never powered down.
  for (genvar r = 0; r < 4; r++) begin : g_row
    assign open_row[r] = |open_bk[4*r+:4];
    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        open_bk[4*r+:4] <= 4'h0;
      end else if (rise_en && !iss_cs[r]) begin
        if (iss_cmd == DCAPI_ACT) begin
          open_bk[4*r+iss_bank] <= 1'b1;
        end else if (iss_cmd == DCAPI_PRE && iss_addr[`DCAPI_A10]) begin
          open_bk[4*r+:4] <= 4'h0;
        end else if (iss_cmd == DCAPI_PRE) begin
          open_bk[4*r+iss_bank] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state           <= ST_INIT_WAIT;
      wt              <= 16'(INIT_WAIT_CYC);
      step            <= 3'h0;
      wb              <= 2'h0;
      init_done       <= 1'b0;
      in_self_refresh <= 1'b0;
    end else begin
      if (wt != 16'h0000) begin
        wt <= wt - 16'h0001;
      end
      case (state)
        ST_INIT_WAIT: if (rise_en && wt == 16'h0000) begin
          state <= ST_INIT_SEQ;
          wt    <= GAP;
        end
        ST_INIT_SEQ: if (rise_en && wt == 16'h0000) begin
          step <= step + 3'h1;
          wt   <= GAP;
          if (step == 3'(`DCAPI_INIT_STEPS - 1)) begin
            state     <= ST_IDLE;
            init_done <= 1'b1;
          end
        end
        ST_IDLE: if (sref_go) begin
          state           <= ST_SREF;
          in_self_refresh <= 1'b1;
        end else if (take && wr_cmd) begin
          state <= ST_WRITE;
          wb    <= 2'h0;
        end
        ST_WRITE: if (fifo_pop) begin
          wb <= wb + 2'h1;
        end else if (rise_en && wb == 2'h2) begin
          state <= ST_IDLE;
        end
        ST_SREF: if (rise_en && !suspend_req) begin
          state           <= ST_SREF_EXIT;
          in_self_refresh <= 1'b0;
          wt              <= XSR;
        end
        ST_SREF_EXIT: if (rise_en && wt == 16'h0000) begin
          state <= ST_IDLE;
        end
        default: state <= ST_INIT_WAIT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Write data: one word per clock edge, strobe moved to mid-eye.

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mem_data_bus_out     <= 64'h0000_0000_0000_0000;
      mem_data_bus_oe      <= 1'b0;
      byte_lane_strobe_out <= 8'h00;
      byte_lane_strobe_oe  <= 1'b0;
    end else begin
      if (fifo_pop) begin
        mem_data_bus_out    <= fifo_data;
        mem_data_bus_oe     <= 1'b1;
        byte_lane_strobe_oe <= 1'b1;
      end else if (state == ST_WRITE && rise_en && wb == 2'h2) begin
        mem_data_bus_oe     <= 1'b0;
        byte_lane_strobe_oe <= 1'b0;
      end
      if (mid_en && mem_data_bus_oe) begin
        byte_lane_strobe_out <= {8{clk_q}};
      end else if (!mem_data_bus_oe) begin
        byte_lane_strobe_out <= 8'h00;
      end
    end
  end

  dcapi_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Read capture.

  dcapi_rd_if rd ();

  assign rd.dq_pin  = mem_data_bus_in;
  assign rd.dqs_pin = byte_lane_strobe_in;
  assign rd.listen  = ~mem_data_bus_oe;
  assign rd_valid   = rd.beat_valid;
  assign rd_data    = rd.beat_data;

  dcapi_capture #(
    .LANES (8)
  ) u_capture (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .rd      (rd.capt)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_sref_cmd;
    row_select_n == 4'h0 && !row_strobe_n && !col_strobe_n && write_en_n && row_clk_en == 4'h0;
  endsequence

  sequence s_cmd_echo;
    row_select_n == ~$past(rank_hot) && {row_strobe_n, col_strobe_n, write_en_n} == $past(cmd_code);
  endsequence

  a_clk_pair: assert property (mem_clk_out_comp == ~mem_clk_out_true)
    else $error("memory clock pair not complementary");
  a_cmd_on_rise: assert property ($changed({row_select_n, mux_row_col_addr, bank_sel,
      row_strobe_n, col_strobe_n, write_en_n}) |-> $rose(mem_clk_out_true[0]))
    else $error("command pins moved off the clock rise");
  a_cke_on_rise: assert property ($changed(row_clk_en) |-> $rose(mem_clk_out_true[0]))
    else $error("clock enable moved off the clock rise");
  a_addr_copy: assert property (addr_low_copy == mux_row_col_addr[5:1])
    else $error("address copy differs from address");
  a_cmd_echo: assert property (take |=> s_cmd_echo)
    else $error("taken command not driven on the pins");
  a_sref_entry: assert property ($rose(in_self_refresh) |-> s_sref_cmd)
    else $error("self-refresh entered without its command");
  a_pd_closed: assert property ((~row_clk_en & open_row) == 4'h0)
    else $error("row with an open bank powered down");
  a_init_cke: assert property ($rose(row_clk_en[0]) && !init_done |-> row_select_n == 4'hf)
    else $error("clock enable raised during a command");
  a_dq_write: assert property (mem_data_bus_oe |-> state == ST_WRITE)
    else $error("data bus driven outside a write");
  a_dqs_centre: assert property (mem_data_bus_oe && $changed(byte_lane_strobe_out)
      |-> ph == CW'(HALF / 2))
    else $error("write strobe not centred in the data");
endmodule : dcapi_channel

// ==== test/dcapi_dram_model.sv ====
/*
  Behavioural DRAM rows: answers each read command with one strobed two-beat burst.
  Assumes the controller's command pins and a 160 ns returned strobe period.
*/
`timescale 1ns/10ps
module dcapi_dram_model (
  input  wire logic        clk_sys,
  input  wire logic [3:0]  row_select_n,
  input  wire logic [2:0]  cmd_pins,
  input  wire logic [12:0] addr,
  output logic [63:0]      dq,
  output logic [7:0]       dqs
);
  int          k;
  logic [12:0] a;

  function automatic logic [63:0] beat(input logic [12:0] col, input int b);
    for (int n = 0; n < 8; n++) begin
      beat[8*n+:8] = {col[3:0], n[2:0], b[0]};
    end
  endfunction : beat

  initial begin
    dq  = 64'h0000_0000_0000_0000;
    dqs = 8'h00;
  end

  // Strobes stand still between bursts; released data shows the inverse of the last beat,
  // so a capture outside a strobe edge cannot pass by chance.
  always @(posedge clk_sys) begin
    if (row_select_n != 4'hf && cmd_pins == 3'h5) begin
      a = addr;
      #67.3;
      for (k = 0; k < 2; k++) begin
        dq  = beat(a, k);
        dqs = {8{~k[0]}};
        #80;
      end
      dq = ~dq;
    end
  end
endmodule : dcapi_dram_model

// ==== test/dcapi_channel_tb_top.sv ====
/*
  Top bench for the channel A pin interface: commands, write data, reads and power states.
  Assumes the DRAM model answers reads and the hand-over timing of the design.
*/
`timescale 1ns/10ps
module dcapi_channel_tb_top;
  import dcapi_pkg::*;
  logic        clk_sys = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0;
  logic        suspend_req = 1'b0, cmd_ready, wr_ready, rd_valid, init_done, in_self_refresh;
  logic        row_strobe_n, col_strobe_n, write_en_n, mem_data_bus_oe, byte_lane_strobe_oe;
  logic        prev_t, tg = 1'b0;
  logic [2:0]  cmd_code = 3'h7;
  logic [1:0]  cmd_rank = 2'h0, cmd_bank = 2'h0, bank_sel;
  logic [12:0] cmd_addr = 13'h0000, mux_row_col_addr;
  logic [3:0]  pd_req = 4'h0, row_select_n, row_clk_en;
  logic [5:0]  mem_clk_out_true, mem_clk_out_comp;
  logic [5:1]  addr_low_copy;
  logic [63:0] wr_data = 64'h0000_0000_0000_0000, rd_data, mem_data_bus_in, mem_data_bus_out;
  logic [7:0]  byte_lane_strobe_in, byte_lane_strobe_out;
  logic [25:0] prev;
  logic [63:0] rq[$];
  logic [31:0] rng = 32'h0000_0006;
  int          err_total = 0, n_tests = 0, cyc = 0, run = 0;
  wire  [25:0] pins = {row_select_n, row_clk_en, row_strobe_n, col_strobe_n, write_en_n,
                       bank_sel, mux_row_col_addr};
  dcapi_cmd_t  codes[8] = '{DCAPI_ACT, DCAPI_WR, DCAPI_RD, DCAPI_BST, DCAPI_PRE, DCAPI_REF,
                            DCAPI_MRS, DCAPI_NOP};

  always #4 clk_sys = ~clk_sys;

  dcapi_channel #(.INIT_WAIT_CYC(20)) i_dut (
    .clk_sys, .nrst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_rank, .cmd_bank, .cmd_addr,
    .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_data, .suspend_req, .pd_req, .init_done,
    .in_self_refresh, .mem_clk_out_true, .mem_clk_out_comp, .row_select_n, .row_clk_en,
    .mux_row_col_addr, .addr_low_copy, .bank_sel, .row_strobe_n, .col_strobe_n, .write_en_n,
    .mem_data_bus_in, .mem_data_bus_out, .mem_data_bus_oe, .byte_lane_strobe_in,
    .byte_lane_strobe_out, .byte_lane_strobe_oe);

  dcapi_dram_model i_dram (.clk_sys, .row_select_n,
    .cmd_pins({row_strobe_n, col_strobe_n, write_en_n}), .addr(mux_row_col_addr),
    .dq(mem_data_bus_in), .dqs(byte_lane_strobe_in));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Holds valid across both words so the strobe is never assigned twice in one step.
  task automatic push2(input logic [63:0] w0, input logic [63:0] w1);
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_data  <= w0;
    for (int w = 0; w < 2; w++) begin
      @(negedge clk_sys);
      for (int i = 0; i < 99 && wr_ready !== 1'b1; i++) @(negedge clk_sys);
      @(posedge clk_sys);
      wr_data <= w1;
    end
    wr_valid <= 1'b0;
  endtask : push2

  task automatic issue(input logic [2:0] c, input logic [1:0] r, input logic [1:0] b,
                       input logic [12:0] a);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_rank  <= r;
    cmd_bank  <= b;
    cmd_addr  <= a;
    @(negedge clk_sys);
    for (int i = 0; i < 999 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    @(negedge clk_sys);
    chk({row_select_n, row_strobe_n, col_strobe_n, write_en_n, bank_sel, mux_row_col_addr,
         addr_low_copy}, {~(4'h1 << r), c, b, a, a[5:1]});
  endtask : issue

  always @(negedge clk_sys) begin
    if (nrst) begin
      chk({mem_clk_out_true, mem_clk_out_comp},
          {{6{mem_clk_out_true[0]}}, ~{6{mem_clk_out_true[0]}}});
      if (mem_clk_out_true[0] !== prev_t) begin
        if (tg) chk(run, 2);
        tg  = 1'b1;
        run = 1;
      end else begin
        run++;
      end
      if (pins !== prev) chk(mem_clk_out_true[0] & ~prev_t, 1'b1);
      if (rd_valid === 1'b1) chk(rd_data, rq.size() > 0 ? rq.pop_front() : 64'hx);
    end
    prev   <= pins;
    prev_t <= mem_clk_out_true[0];
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] r;
    logic [63:0] w0, w1;
    int          n;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 999 && init_done !== 1'b1; i++) @(negedge clk_sys);
    chk({init_done, row_clk_en}, 5'h1f);
    for (int j = 0; j < 8; j++) begin
      r  = xs();
      w0 = {xs(), xs()};
      w1 = {xs(), xs()};
      if (codes[j] == DCAPI_WR) push2(w0, w1);
      if (codes[j] == DCAPI_RD) begin
        rq.push_back(i_dram.beat(r[12:0], 0));
        rq.push_back(i_dram.beat(r[12:0], 1));
      end
      issue(codes[j], r[14:13], r[16:15], r[12:0]);
      if (codes[j] == DCAPI_WR) begin
        for (int i = 0; i < 20 && mem_data_bus_oe !== 1'b1; i++) @(negedge clk_sys);
        for (int i = 0; i < 4; i++) begin
          chk({byte_lane_strobe_oe, byte_lane_strobe_out, mem_data_bus_out},
              {1'b1, {8{i == 1 || i == 2}}, i < 2 ? w0 : w1});
          @(negedge clk_sys);
        end
      end
      repeat (40) @(negedge clk_sys);
    end
    issue(DCAPI_PRE, 2'h2, 2'h0, 13'h0400);
    @(posedge clk_sys);
    pd_req <= 4'h4;
    repeat (12) @(negedge clk_sys);
    chk(row_clk_en, 4'hb);
    @(posedge clk_sys);
    pd_req      <= 4'h0;
    suspend_req <= 1'b1;
    for (int i = 0; i < 99 && in_self_refresh !== 1'b1; i++) @(negedge clk_sys);
    chk({in_self_refresh, row_clk_en}, 5'h10);
    @(posedge clk_sys);
    suspend_req <= 1'b0;
    for (int i = 0; i < 99 && in_self_refresh !== 1'b0; i++) @(negedge clk_sys);
    chk({in_self_refresh, row_clk_en}, 5'h0f);
    issue(DCAPI_ACT, 2'h3, 2'h1, 13'h1fff);
    // The FIFO is filled while no write drains it, then emptied by write bursts.
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    n = 0;
    repeat (40) begin
      @(negedge clk_sys);
      n += int'(wr_ready);
    end
    @(posedge clk_sys);
    wr_valid <= 1'b0;
    chk(n, 32);
    repeat (16) issue(DCAPI_WR, 2'h0, 2'h0, 13'h0000);
    repeat (20) @(negedge clk_sys);
    chk({wr_ready, rq.size()}, {1'b1, 32'h0000_0000});
    report_and_stop();
  end
endmodule : dcapi_channel_tb_top
